// ---- asac_pkg.sv ----
// package: register map, field layout and reset values of the adc aux control block
package asac_pkg;
  localparam logic [7:0]  ADDR_TEMP_CTRL   = 8'h40;
  localparam logic [7:0]  ADDR_FIFO_FLUSH  = 8'h44;
  localparam logic [7:0]  ADDR_WAIT_CNT    = 8'h48;
  localparam logic [7:0]  ADDR_SEQ0_MUX    = 8'h4C;
  localparam int          TEMP_EN_BIT      = 0;
  localparam int          TEMP_CHSW_BIT    = 1;
  localparam int          TEMP_AVG_LSB     = 4;
  localparam int          TEMP_AVG_W       = 3;
  localparam int          FLUSH_N          = 4;
  localparam int          WAIT_CNT_LSB     = 0;
  localparam int          WAIT_INI_LSB     = 8;
  localparam int          WAIT_W           = 8;
  localparam int          MUX_W            = 3;
  localparam int          MUX_STRIDE       = 4;
  localparam int          MUX_N            = 8;
  localparam logic [31:0] RST_VALUE        = 32'h0000_0000;
  localparam logic [31:0] MASK_TEMP_CTRL   = 32'h0000_0073;
  localparam logic [31:0] MASK_WAIT_CNT    = 32'h0000_FFFF;
  localparam logic [31:0] MASK_SEQ0_MUX    = 32'h7777_7777;
  typedef enum logic [2:0] {
    ASAC_IDLE = 3'b001,
    ASAC_WAIT = 3'b010,
    ASAC_FIRE = 3'b100
  } asac_state_t;
endpackage

// ---- asac_top.sv ----
// top: register file and control outputs of the adc aux control block
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - temp enable bit 0 powers up the temperature sensing module
// - channel switch bit 1 routes every adc input to the temperature sensor
// - writing one to flush bits 3:0 resets that sequencer fifo; self-clearing
// - after a conversion end seen outside a wait, wait the programmed cycles before next start; an end during a wait is ignored
// - eight-bit wait initial value in bits 15:8, read/write, resets to zero
// - sequencer 0 has eight three-bit input selects, spaced four bits apart
module asac_top
  import asac_pkg::*;
(
  input  wire logic                  ref_clk_i,
  input  wire logic                  srst_i,
  input  wire logic [7:0]            addr_i,
  input  wire logic [31:0]           wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic [31:0]                rdata_o,
  input  wire logic                  conv_end_i,
  output logic                       conv_start_o,
  output logic                       temp_module_enable_o,
  output logic                       temp_channel_switch_o,
  output logic [TEMP_AVG_W-1:0]      temp_averaging_setting_o,
  output logic [FLUSH_N-1:0]         seq_fifo_flush_o,
  output logic [MUX_N*MUX_W-1:0]     seq0_input_select_o
);
  logic [31:0]          temperature_sense_control;
  logic [31:0]          conversion_wait_counter;
  logic [31:0]          sequencer0_input_select;
  logic                 timer_waiting;
  logic [31:0]          next_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // address decode
  wire hit_temp  = (addr_i == ADDR_TEMP_CTRL);
  wire hit_flush = (addr_i == ADDR_FIFO_FLUSH);
  wire hit_wait  = (addr_i == ADDR_WAIT_CNT);
  wire hit_mux   = (addr_i == ADDR_SEQ0_MUX);
  wire wr_temp   = wr_i && hit_temp;
  wire wr_flush  = wr_i && hit_flush;
  wire wr_wait   = wr_i && hit_wait;
  wire wr_mux    = wr_i && hit_mux;

  // reserved bits are masked off on write so they always read zero
  wire [31:0] temp_wval = wdata_i & MASK_TEMP_CTRL;
  wire [31:0] wait_wval = wdata_i & MASK_WAIT_CNT;
  wire [31:0] mux_wval  = wdata_i & MASK_SEQ0_MUX;
  wire [FLUSH_N-1:0] flush_pulse = wr_flush ? wdata_i[FLUSH_N-1:0] : {FLUSH_N{1'b0}};

  // mux fields packed 3 bits each; bit 3 of every nibble is reserved
  wire [MUX_N*MUX_W-1:0] mux_fields;
  for (genvar g = 0; g < MUX_N; g++) begin : g_mux
    assign mux_fields[g*MUX_W +: MUX_W] = wdata_i[g*MUX_STRIDE +: MUX_W];
  end

  // flush bits read zero: they are strobes and clear themselves after one cycle
  always_comb begin
    next_rdata = RST_VALUE;
    if (hit_temp) begin
      next_rdata = temperature_sense_control;
    end else if (hit_wait) begin
      next_rdata = conversion_wait_counter;
    end else if (hit_mux) begin
      next_rdata = sequencer0_input_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      temperature_sense_control <= RST_VALUE;
      conversion_wait_counter   <= RST_VALUE;
      sequencer0_input_select   <= RST_VALUE;
      rdata_o                   <= RST_VALUE;
    end else begin
      if (wr_temp) begin
        temperature_sense_control <= temp_wval;
      end
      if (wr_wait) begin
        conversion_wait_counter <= wait_wval;
      end
      if (wr_mux) begin
        sequencer0_input_select <= mux_wval;
      end
      rdata_o <= rd_i ? next_rdata : RST_VALUE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control outputs, all registered
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      temp_module_enable_o     <= 1'b0;
      temp_channel_switch_o    <= 1'b0;
      temp_averaging_setting_o <= '0;
      seq_fifo_flush_o         <= '0;
      seq0_input_select_o      <= '0;
    end else begin
      temp_module_enable_o     <= wr_temp ? temp_wval[TEMP_EN_BIT] : temp_module_enable_o;
      temp_channel_switch_o    <= wr_temp ? temp_wval[TEMP_CHSW_BIT] : temp_channel_switch_o;
      temp_averaging_setting_o <= wr_temp ? temp_wval[TEMP_AVG_LSB +: TEMP_AVG_W]
                                          : temp_averaging_setting_o;
      seq_fifo_flush_o         <= flush_pulse;
      seq0_input_select_o      <= wr_mux ? mux_fields : seq0_input_select_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // inter-conversion wait; the initial value field is held for software only
  asac_wait_timer #(
    .W (WAIT_W)
  ) u_timer (
    .ref_clk_i     (ref_clk_i),
    .srst_i        (srst_i),
    .conv_end_i    (conv_end_i),
    .wait_cycles_i (conversion_wait_counter[WAIT_CNT_LSB +: WAIT_W]),
    .conv_start_o  (conv_start_o),
    .waiting_o     (timer_waiting)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  flush_pulse_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (wr_flush && wdata_i[0]) |=> seq_fifo_flush_o[0] ##1 (!seq_fifo_flush_o[0] || $past(wr_flush && wdata_i[0])))
    else $error("flush strobe not a single pulse");
  flush_zero_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    !wr_flush |=> (seq_fifo_flush_o == 4'h0))
    else $error("flush asserted without a write");
  temp_en_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    wr_temp |=> (temp_module_enable_o == $past(wdata_i[0])))
    else $error("temperature enable does not follow write");
  temp_sw_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    wr_temp |=> (temp_channel_switch_o == $past(wdata_i[1])))
    else $error("channel switch does not follow write");
  temp_avg_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    wr_temp |=> (temp_averaging_setting_o == $past(wdata_i[6:4])))
    else $error("averaging setting not stored");
  wait_init_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (wr_wait ##1 !wr_i ##1 (rd_i && hit_wait)) |=> (rdata_o[15:8] == $past(wdata_i[15:8], 3)))
    else $error("wait initial value readback wrong");
  mux_last_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    wr_mux |=> (seq0_input_select_o[23:21] == $past(wdata_i[30:28])))
    else $error("eighth sample select wrong");
  resv_zero_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    rd_i && hit_temp |=> (rdata_o[31:7] == 25'h0000000) && (rdata_o[3:2] == 2'h0))
    else $error("reserved bits read nonzero");
  cover_flush_c: cover property (@(posedge ref_clk_i) disable iff (srst_i) wr_flush && wdata_i[3]);
  cover_temp_c: cover property (@(posedge ref_clk_i) disable iff (srst_i) temp_module_enable_o && temp_channel_switch_o);
  cover_start_c: cover property (@(posedge ref_clk_i) disable iff (srst_i) conv_end_i ##[1:300] conv_start_o);
  cover_waiting_c: cover property (@(posedge ref_clk_i) disable iff (srst_i) timer_waiting ##1 conv_start_o);
endmodule

// ---- asac_top_test.sv ----
// self-checking bench for the adc aux control block: register access, control outputs, wait timer
module asac_top_test;
  import asac_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic                  ref_clk_i;
  logic                  srst_i;
  logic [7:0]            addr_i;
  logic [31:0]           wdata_i;
  logic                  wr_i;
  logic                  rd_i;
  logic [31:0]           rdata_o;
  logic                  conv_end_i;
  logic                  conv_start_o;
  logic                  temp_module_enable_o;
  logic                  temp_channel_switch_o;
  logic [TEMP_AVG_W-1:0] temp_averaging_setting_o;
  logic [FLUSH_N-1:0]    seq_fifo_flush_o;
  logic [MUX_N*MUX_W-1:0] seq0_input_select_o;
  int                    fail_count;
  int                    samples_checked;
  logic [23:0]           mux_exp;

  asac_top DUT (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .conv_end_i(conv_end_i), .conv_start_o(conv_start_o),
    .temp_module_enable_o(temp_module_enable_o), .temp_channel_switch_o(temp_channel_switch_o),
    .temp_averaging_setting_o(temp_averaging_setting_o), .seq_fifo_flush_o(seq_fifo_flush_o),
    .seq0_input_select_o(seq0_input_select_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    if (fail_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // bus cycles end at the edge that takes them, so effects are looked at 1 ns later
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_i   <= 1'b0;
    #1;
    check(rdata_o, exp);
    @(posedge ref_clk_i);
    #1;
    check(rdata_o, 32'h0000_0000);
  endtask

  // one conversion end, then count edges until the next start; for waits above three a second end mid-wait must be ignored
  task conv(input logic [7:0] n);
    int cnt;
    wr(ADDR_WAIT_CNT, {24'h00_0000, n});
    @(posedge ref_clk_i);
    conv_end_i <= 1'b1;
    cnt = 0;
    while (conv_start_o !== 1'b1 && cnt < 300) begin
      @(posedge ref_clk_i);
      conv_end_i <= (n > 8'h03 && cnt == 1);
      #1;
      cnt++;
    end
    check(cnt, 32'(n) + 32'h1);
    @(posedge ref_clk_i);
    #1;
    check({31'h0, conv_start_o}, 32'h0000_0000);
    repeat (3) @(posedge ref_clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fail_count++;
    test_done();
  end

  initial begin
    fail_count = 0;
    samples_checked = 0;
    srst_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0000_0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    conv_end_i = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    rd(ADDR_TEMP_CTRL, 32'h0000_0000);
    rd(ADDR_WAIT_CNT, 32'h0000_0000);
    rd(ADDR_SEQ0_MUX, 32'h0000_0000);
    check({8'h00, seq0_input_select_o}, 32'h0000_0000);
    // every writable bit set: reserved bits must be dropped
    wr(ADDR_TEMP_CTRL, 32'hFFFF_FFFF);
    check({29'h0, temp_averaging_setting_o}, 32'h0000_0007);
    check({31'h0, temp_module_enable_o}, 32'h0000_0001);
    check({31'h0, temp_channel_switch_o}, 32'h0000_0001);
    rd(ADDR_TEMP_CTRL, 32'h0000_0073);
    wr(ADDR_TEMP_CTRL, 32'h0000_0052);
    check({31'h0, temp_module_enable_o}, 32'h0000_0000);
    check({31'h0, temp_channel_switch_o}, 32'h0000_0001);
    check({29'h0, temp_averaging_setting_o}, 32'h0000_0005);
    // flush pulses last one cycle; zeros and reserved bits do nothing
    wr(ADDR_FIFO_FLUSH, 32'hFFFF_FFFA);
    check({28'h0, seq_fifo_flush_o}, 32'h0000_000A);
    @(posedge ref_clk_i);
    #1;
    check({28'h0, seq_fifo_flush_o}, 32'h0000_0000);
    wr(ADDR_FIFO_FLUSH, 32'h0000_0005);
    check({28'h0, seq_fifo_flush_o}, 32'h0000_0005);
    wr(ADDR_FIFO_FLUSH, 32'h0000_0000);
    check({28'h0, seq_fifo_flush_o}, 32'h0000_0000);
    rd(ADDR_FIFO_FLUSH, 32'h0000_0000);
    wr(ADDR_WAIT_CNT, 32'hFFFF_AB03);
    rd(ADDR_WAIT_CNT, 32'h0000_AB03);
    // input selects: each sample gets its own index, then all ones
    wr(ADDR_SEQ0_MUX, 32'h7654_3210);
    for (int k = 0; k < MUX_N; k++) mux_exp[MUX_W*k +: MUX_W] = k[2:0];
    check({8'h00, seq0_input_select_o}, {8'h00, mux_exp});
    rd(ADDR_SEQ0_MUX, 32'h7654_3210);
    wr(ADDR_SEQ0_MUX, 32'hFFFF_FFFF);
    check({8'h00, seq0_input_select_o}, 32'h00FF_FFFF);
    rd(ADDR_SEQ0_MUX, 32'h7777_7777);
    // unmapped place: write ignored, read zero, temperature control register untouched
    wr(8'h50, 32'hFFFF_FFFF);
    rd(8'h50, 32'h0000_0000);
    rd(ADDR_TEMP_CTRL, 32'h0000_0052);
    conv(8'h00);
    conv(8'h01);
    conv(8'h03);
    conv(8'h05);
    conv(8'hFF);
    srst_i <= 1'b1;
    @(posedge ref_clk_i);
    srst_i <= 1'b0;
    #1;
    check({31'h0, temp_channel_switch_o}, 32'h0000_0000);
    rd(ADDR_WAIT_CNT, 32'h0000_0000);
    test_done();
  end
endmodule

// ---- asac_wait_timer.sv ----
// inter-conversion wait timer: counts wait cycles after each conversion end that arrives outside a wait
module asac_wait_timer
  import asac_pkg::*;
#(
  parameter int W = WAIT_W
) (
  input  wire logic         ref_clk_i,
  input  wire logic         srst_i,
  input  wire logic         conv_end_i,
  input  wire logic [W-1:0] wait_cycles_i,
  output logic              conv_start_o,
  output logic              waiting_o
);
  asac_state_t   state;
  asac_state_t   next_state;
  logic [W-1:0]  cnt;
  logic [W-1:0]  next_cnt;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ASAC_IDLE: begin
        next_cnt = '0;
        if (conv_end_i) begin
          next_state = (wait_cycles_i == '0) ? ASAC_FIRE : ASAC_WAIT;
        end
      end
      ASAC_WAIT: begin
        next_cnt = cnt + 1'b1;
        // a wait of n cycles ends after the n-th counted cycle
        if (W'(cnt + 1'b1) == wait_cycles_i) begin
          next_state = ASAC_FIRE;
        end
      end
      ASAC_FIRE: begin
        next_cnt   = '0;
        next_state = conv_end_i ? ((wait_cycles_i == '0) ? ASAC_FIRE : ASAC_WAIT) : ASAC_IDLE;
      end
      default: begin
        next_state = ASAC_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state        <= ASAC_IDLE;
      cnt          <= '0;
      conv_start_o <= 1'b0;
      waiting_o    <= 1'b0;
    end else begin
      state        <= next_state;
      cnt          <= next_cnt;
      conv_start_o <= (next_state == ASAC_FIRE);
      waiting_o    <= (next_state == ASAC_WAIT);
    end
  end

  // state samples fire one edge after the n-th counted cycle, hence four edges for a wait of three
  wait_start_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (state == ASAC_IDLE && conv_end_i && wait_cycles_i == 8'h03) |-> ##4 (state == ASAC_FIRE))
    else $error("start not issued after the wait count");
  wait_zero_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (state == ASAC_IDLE && conv_end_i && wait_cycles_i == 8'h00) |=> conv_start_o)
    else $error("zero wait did not start at once");
  wait_quiet_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
    (state == ASAC_WAIT && W'(cnt + 1'b1) != wait_cycles_i) |=> (state == ASAC_WAIT && !conv_start_o))
    else $error("start issued while still waiting");
  cover_wait_c: cover property (@(posedge ref_clk_i) disable iff (srst_i)
    (state == ASAC_WAIT) ##1 (state == ASAC_FIRE));
endmodule
